// file: smcf_top.sv
/*
 smcf_top: spi slave command front end of a serial byte memory.
 assumes: sck, cs_n and si come from an spi master outside the clock domain;
 the so pin is resolved outside from o_so and o_so_oe.
*/
// Operation
// - while deselected, si is ignored and so is not driven.
// - each command starts at a select fall; one opcode per select.
// - si sampled at sck rise, so changed at sck fall, msb first.
// - opcodes, addresses and data travel most significant bit first.
// - two address bytes; only the low 15 bits are used.
// - the first eight bits after select form the opcode.
// - unknown opcode: no action, ignore si until next select, so idle.
// - sck level at select fall picks mode 0 (low) or mode 3 (high).
// - in mode 3 capture starts at first rise after sck goes low.
// - decode set write enable, write status and write memory opcodes.
// - decode clear write enable, read status and memory read opcodes.
// - decode fast read, sleep and read identity; nine opcodes in all.
// - write enable flag is clear after power-up.
// - status and memory writes only accepted while write enable is set.
// - set write enable sets the flag; the status byte written does not change it.
// - flag clears at select rise after clear, status write or memory write.
// - clear write enable command clears the flag; status bit 1 then shows zero.
// - slave only; acts solely upon master commands under select.
// - write enable flag is bit 1 of the 8-bit status register.
// - so driven only while returning read data.
`timescale 1ns/100ps
module smcf_top #(
    parameter int P_PU_CYCLES = smcf_pkg::POWER_UP_CYCLES
) (
    // clock and reset
    input  wire logic                          i_clk_sys,
    input  wire logic                          i_srst,
    // spi pins
    input  wire logic                          i_sck,
    input  wire logic                          i_cs_n,
    input  wire logic                          i_si,
    output logic                               o_so,
    output logic                               o_so_oe,
    // status
    output logic                               o_ready,
    output logic                               o_mode3,
    output logic                               o_wen,
    output logic [7:0]                         o_status,
    // decoded command
    output logic [7:0]                         o_opcode,
    output logic                               o_opcode_vld,
    output logic                               o_opcode_bad,
    output logic [smcf_pkg::ADDR_BITS-1:0]     o_addr,
    output logic                               o_addr_vld
);
    localparam logic [15:0] PU_LAST = 16'(P_PU_CYCLES - 1);

    logic [2:0]                     sync_q;
    logic                           sck_s;
    logic                           cs_s;
    logic                           si_s;
    logic                           sck_d_ff;
    logic                           cs_d_ff;
    logic [15:0]                    pu_cnt_ff;
    logic                           ready_ff;
    logic                           sel_ff;
    logic                           mode3_ff;
    logic                           armed_ff;
    smcf_pkg::smcf_state_e          st_ff;
    logic [7:0]                     op_ff;
    logic                           op_done_ff;
    logic                           op_vld_ff;
    logic                           op_bad_ff;
    logic                           hi_sel_ff;
    logic [7:0]                     addr_hi_ff;
    logic [smcf_pkg::ADDR_BITS-1:0] addr_ff;
    logic                           addr_vld_ff;
    logic                           wen_ff;
    logic [2:0]                     prot_ff;
    logic [7:0]                     out_sh_ff;
    logic                           so_ff;
    logic                           oe_ff;

    logic [15:0]                    nxt_pu_cnt;
    logic                           nxt_ready;
    logic                           nxt_sel;
    logic                           nxt_mode3;
    logic                           nxt_armed;
    smcf_pkg::smcf_state_e          nxt_st;
    logic [7:0]                     nxt_op;
    logic                           nxt_op_done;
    logic                           nxt_op_vld;
    logic                           nxt_op_bad;
    logic                           nxt_hi_sel;
    logic [7:0]                     nxt_addr_hi;
    logic [smcf_pkg::ADDR_BITS-1:0] nxt_addr;
    logic                           nxt_addr_vld;
    logic                           nxt_wen;
    logic [2:0]                     nxt_prot;
    logic [7:0]                     nxt_out_sh;
    logic                           nxt_so;
    logic                           nxt_oe;

    logic                           sck_rise;
    logic                           sck_fall;
    logic                           cs_rise;
    logic                           cs_fall;
    logic                           sh_clr;
    logic                           sh_take;
    logic                           sh_last;
    logic [2:0]                     sh_cnt;
    logic [7:0]                     sh_byte;
    logic [7:0]                     status_now;
    logic                           clears_wen;

    // pins into the clock domain
    smcf_sync #(.W(3), .RST(smcf_pkg::PIN_RESET)) u_sync (
        .i_clk_sys (i_clk_sys),
        .i_srst    (i_srst),
        .i_d       ({i_sck, i_cs_n, i_si}),
        .o_q       (sync_q)
    );
    assign sck_s = sync_q[2];
    assign cs_s  = sync_q[1];
    assign si_s  = sync_q[0];

    assign sck_rise = sck_s && !sck_d_ff;
    assign sck_fall = !sck_s && sck_d_ff;
    assign cs_rise  = cs_s && !cs_d_ff;
    assign cs_fall  = !cs_s && cs_d_ff;

    assign status_now = {prot_ff[2], 3'h0, prot_ff[1:0], wen_ff, 1'b0};
    assign clears_wen = (op_ff == smcf_pkg::CLEAR_WRITE_ENABLE_CMD) ||
                        (op_ff == smcf_pkg::WRITE_STATUS_CMD) ||
                        (op_ff == smcf_pkg::WRITE_MEMORY_CMD);

    // capture only at armed rising edges in a receiving state
    assign sh_take = sel_ff && !cs_rise && sck_rise && armed_ff &&
                     ((st_ff == smcf_pkg::ST_OPCODE) ||
                      (st_ff == smcf_pkg::ST_ADDR) ||
                      (st_ff == smcf_pkg::ST_STIN));

    smcf_shift u_shift (
        .i_clk_sys (i_clk_sys),
        .i_srst    (i_srst),
        .i_clr     (sh_clr),
        .i_en      (sh_take),
        .i_bit     (si_s),
        .o_cnt     (sh_cnt),
        .o_last    (sh_last),
        .o_byte    (sh_byte)
    );

    always_comb
    begin
        nxt_pu_cnt   = pu_cnt_ff;
        nxt_ready    = ready_ff;
        nxt_sel      = sel_ff;
        nxt_mode3    = mode3_ff;
        nxt_armed    = armed_ff;
        nxt_st       = st_ff;
        nxt_op       = op_ff;
        nxt_op_done  = op_done_ff;
        nxt_op_vld   = 1'b0;
        nxt_op_bad   = 1'b0;
        nxt_hi_sel   = hi_sel_ff;
        nxt_addr_hi  = addr_hi_ff;
        nxt_addr     = addr_ff;
        nxt_addr_vld = 1'b0;
        nxt_wen      = wen_ff;
        nxt_prot     = prot_ff;
        nxt_out_sh   = out_sh_ff;
        nxt_so       = so_ff;
        nxt_oe       = oe_ff;
        sh_clr       = 1'b0;
        if (!ready_ff)
        begin
            nxt_pu_cnt = pu_cnt_ff + 16'h0001;
            nxt_ready  = (pu_cnt_ff == PU_LAST);
        end
        if (cs_rise)
        begin
            if (sel_ff && op_done_ff && clears_wen)
            begin
                nxt_wen = 1'b0;
            end
            nxt_sel = 1'b0;
            nxt_st  = smcf_pkg::ST_IDLE;
            nxt_oe  = 1'b0;
            nxt_so  = 1'b0;
        end
        else if (cs_fall && ready_ff)
        begin
            nxt_sel     = 1'b1;
            nxt_mode3   = sck_s;
            nxt_armed   = !sck_s;
            nxt_st      = smcf_pkg::ST_OPCODE;
            nxt_op_done = 1'b0;
            nxt_hi_sel  = 1'b0;
            sh_clr      = 1'b1;
        end
        else if (sel_ff)
        begin
            if (sck_fall)
            begin
                nxt_armed = 1'b1;
                if (st_ff == smcf_pkg::ST_STOUT)
                begin
                    nxt_so     = out_sh_ff[7];
                    nxt_oe     = 1'b1;
                    nxt_out_sh = {out_sh_ff[6:0], out_sh_ff[7]};
                end
            end
            if (sh_last)
            begin
                case (st_ff)
                    smcf_pkg::ST_OPCODE:
                    begin
                        nxt_op      = sh_byte;
                        nxt_op_vld  = 1'b1;
                        nxt_op_done = 1'b1;
                        nxt_st      = smcf_pkg::ST_DONE;
                        case (sh_byte)
                            smcf_pkg::SET_WRITE_ENABLE_CMD: nxt_wen = 1'b1;
                            smcf_pkg::CLEAR_WRITE_ENABLE_CMD,
                            smcf_pkg::SLEEP_CMD,
                            smcf_pkg::READ_IDENTITY_CMD: nxt_st = smcf_pkg::ST_DONE;
                            smcf_pkg::READ_STATUS_CMD:
                            begin
                                nxt_st     = smcf_pkg::ST_STOUT;
                                nxt_out_sh = status_now;
                            end
                            smcf_pkg::WRITE_STATUS_CMD:
                                nxt_st = wen_ff ? smcf_pkg::ST_STIN : smcf_pkg::ST_DONE;
                            smcf_pkg::WRITE_MEMORY_CMD:
                                nxt_st = wen_ff ? smcf_pkg::ST_ADDR : smcf_pkg::ST_DONE;
                            smcf_pkg::READ_MEMORY_CMD,
                            smcf_pkg::FAST_READ_CMD: nxt_st = smcf_pkg::ST_ADDR;
                            default:
                            begin
                                nxt_op_vld  = 1'b0;
                                nxt_op_done = 1'b0;
                                nxt_op_bad  = 1'b1;
                                nxt_st      = smcf_pkg::ST_IGNORE;
                            end
                        endcase
                    end
                    smcf_pkg::ST_ADDR:
                    begin
                        if (!hi_sel_ff)
                        begin
                            nxt_addr_hi = sh_byte;
                            nxt_hi_sel  = 1'b1;
                        end
                        else
                        begin
                            nxt_addr     = {addr_hi_ff[6:0], sh_byte};
                            nxt_addr_vld = 1'b1;
                            nxt_st       = smcf_pkg::ST_DONE;
                        end
                    end
                    smcf_pkg::ST_STIN:
                    begin
                        nxt_prot = {sh_byte[smcf_pkg::STATUS_WPEN_BIT],
                                    sh_byte[smcf_pkg::STATUS_BP1_BIT],
                                    sh_byte[smcf_pkg::STATUS_BP0_BIT]};
                        nxt_st   = smcf_pkg::ST_DONE;
                    end
                    default: nxt_st = st_ff;
                endcase
            end
        end
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (i_srst)
        begin
            sck_d_ff    <= 1'b0;
            cs_d_ff     <= 1'b1;
            pu_cnt_ff   <= 16'h0000;
            ready_ff    <= 1'b0;
            sel_ff      <= 1'b0;
            mode3_ff    <= 1'b0;
            armed_ff    <= 1'b0;
            st_ff       <= smcf_pkg::ST_IDLE;
            op_ff       <= 8'h00;
            op_done_ff  <= 1'b0;
            op_vld_ff   <= 1'b0;
            op_bad_ff   <= 1'b0;
            hi_sel_ff   <= 1'b0;
            addr_hi_ff  <= 8'h00;
            addr_ff     <= 15'h0000;
            addr_vld_ff <= 1'b0;
            wen_ff      <= smcf_pkg::STATUS_RESET[smcf_pkg::STATUS_WEN_BIT];
            prot_ff     <= 3'h0;
            out_sh_ff   <= 8'h00;
            so_ff       <= 1'b0;
            oe_ff       <= 1'b0;
        end
        else
        begin
            sck_d_ff    <= sck_s;
            cs_d_ff     <= cs_s;
            pu_cnt_ff   <= nxt_pu_cnt;
            ready_ff    <= nxt_ready;
            sel_ff      <= nxt_sel;
            mode3_ff    <= nxt_mode3;
            armed_ff    <= nxt_armed;
            st_ff       <= nxt_st;
            op_ff       <= nxt_op;
            op_done_ff  <= nxt_op_done;
            op_vld_ff   <= nxt_op_vld;
            op_bad_ff   <= nxt_op_bad;
            hi_sel_ff   <= nxt_hi_sel;
            addr_hi_ff  <= nxt_addr_hi;
            addr_ff     <= nxt_addr;
            addr_vld_ff <= nxt_addr_vld;
            wen_ff      <= nxt_wen;
            prot_ff     <= nxt_prot;
            out_sh_ff   <= nxt_out_sh;
            so_ff       <= nxt_so;
            oe_ff       <= nxt_oe;
        end
    end

    assign o_so         = so_ff;
    assign o_so_oe      = oe_ff;
    assign o_ready      = ready_ff;
    assign o_mode3      = mode3_ff;
    assign o_wen        = wen_ff;
    assign o_status     = status_now;
    assign o_opcode     = op_ff;
    assign o_opcode_vld = op_vld_ff;
    assign o_opcode_bad = op_bad_ff;
    assign o_addr       = addr_ff;
    assign o_addr_vld   = addr_vld_ff;

    // checks
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (i_srst);

    property p_desel_quiet;
        cs_rise |=> !oe_ff [*2];
    endproperty
    a_desel_quiet: assert property (p_desel_quiet) else $error("so driven after deselect");

    property p_so_fall;
        sel_ff && !cs_rise && sck_fall && st_ff == smcf_pkg::ST_STOUT
            |=> oe_ff && so_ff == $past(out_sh_ff[7]);
    endproperty
    a_so_fall: assert property (p_so_fall) else $error("so not updated at sck fall");

    property p_set_wen;
        sh_last && st_ff == smcf_pkg::ST_OPCODE
            && sh_byte == smcf_pkg::SET_WRITE_ENABLE_CMD |=> wen_ff ##1 wen_ff;
    endproperty
    a_set_wen: assert property (p_set_wen) else $error("write enable not set");

    property p_bad_op;
        st_ff == smcf_pkg::ST_IGNORE |-> !oe_ff && !op_vld_ff && !addr_vld_ff;
    endproperty
    a_bad_op: assert property (p_bad_op) else $error("activity after invalid opcode");

    property p_mode_pick;
        cs_fall && ready_ff && !sel_ff |=> sel_ff && mode3_ff == $past(sck_s);
    endproperty
    a_mode_pick: assert property (p_mode_pick) else $error("mode not taken at select");

    property p_mode3_wait;
        sel_ff && !armed_ff |-> sh_cnt == 3'h0 && !sh_take;
    endproperty
    a_mode3_wait: assert property (p_mode3_wait) else $error("capture before first low");

    property p_pu_clear;
        $past(i_srst) |-> !wen_ff && !sel_ff;
    endproperty
    a_pu_clear: assert property (p_pu_clear) else $error("flag set after reset");

    property p_auto_clear;
        cs_rise && sel_ff && op_done_ff && clears_wen |=> !wen_ff;
    endproperty
    a_auto_clear: assert property (p_auto_clear) else $error("flag not cleared");

    property p_status_keep;
        sh_last && st_ff == smcf_pkg::ST_STIN |=> wen_ff == $past(wen_ff);
    endproperty
    a_status_keep: assert property (p_status_keep) else $error("status write moved flag");

    property p_partial;
        cs_rise && st_ff == smcf_pkg::ST_OPCODE |=> wen_ff == $past(wen_ff) && !op_vld_ff;
    endproperty
    a_partial: assert property (p_partial) else $error("partial opcode acted");

    property p_addr;
        sh_last && st_ff == smcf_pkg::ST_ADDR && hi_sel_ff
            |=> addr_vld_ff && addr_ff == {$past(addr_hi_ff[6:0]), $past(sh_byte)};
    endproperty
    a_addr: assert property (p_addr) else $error("address capture wrong");

    c_status_read: cover property (st_ff == smcf_pkg::ST_STOUT && oe_ff);
    c_mode3_sel: cover property (sel_ff && mode3_ff && sh_take);
    c_bad_op: cover property (op_bad_ff);
    c_write_addr: cover property (addr_vld_ff && op_ff == smcf_pkg::WRITE_MEMORY_CMD);

endmodule : smcf_top

// file: smcf_pkg.sv
/*
 smcf_pkg: shared constants of the spi memory command front end.
 assumes: the system clock runs at 125 mhz.
*/
package smcf_pkg;

    // opcodes
    localparam logic [7:0] SET_WRITE_ENABLE_CMD   = 8'h06;
    localparam logic [7:0] CLEAR_WRITE_ENABLE_CMD = 8'h04;
    localparam logic [7:0] READ_STATUS_CMD        = 8'h05;
    localparam logic [7:0] WRITE_STATUS_CMD       = 8'h01;
    localparam logic [7:0] READ_MEMORY_CMD        = 8'h03;
    localparam logic [7:0] FAST_READ_CMD          = 8'h0b;
    localparam logic [7:0] WRITE_MEMORY_CMD       = 8'h02;
    localparam logic [7:0] SLEEP_CMD              = 8'hb9;
    localparam logic [7:0] READ_IDENTITY_CMD      = 8'h9f;

    // status register layout
    localparam int         STATUS_WEN_BIT  = 1;
    localparam int         STATUS_BP0_BIT  = 2;
    localparam int         STATUS_BP1_BIT  = 3;
    localparam int         STATUS_WPEN_BIT = 7;
    localparam logic [7:0] STATUS_RESET    = 8'h00;

    // synchroniser reset levels {sck, cs_n, si}: the idle levels of the pins
    localparam logic [2:0] PIN_RESET = 3'b010;

    // address width used by the memory
    localparam int         ADDR_BITS = 15;

    // power-up delay before the first select is honoured
    localparam int         POWER_UP_DELAY_US = 250;
    localparam int         CLK_MHZ           = 125;
    localparam int         POWER_UP_CYCLES   = POWER_UP_DELAY_US * CLK_MHZ;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_OPCODE = 3'b001,
        ST_ADDR   = 3'b010,
        ST_STIN   = 3'b011,
        ST_STOUT  = 3'b100,
        ST_DONE   = 3'b101,
        ST_IGNORE = 3'b110
    } smcf_state_e;

endpackage : smcf_pkg

// file: smcf_sync.sv
/*
 smcf_sync: two flip-flop synchroniser, one lane per bit.
 assumes: inputs are asynchronous to i_clk_sys.
*/
`timescale 1ns/100ps
module smcf_sync #(
    parameter int           W   = 3,
    parameter logic [W-1:0] RST = '0
) (
    // clock and reset
    input  wire logic         i_clk_sys,
    input  wire logic         i_srst,
    // data
    input  wire logic [W-1:0] i_d,
    output logic      [W-1:0] o_q
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] sync_ff;

    genvar g;
    generate
        for (g = 0; g < W; g++)
        begin : g_lane
            always_ff @(posedge i_clk_sys)
            begin
                if (i_srst)
                begin
                    meta_ff[g] <= RST[g];
                    sync_ff[g] <= RST[g];
                end
                else
                begin
                    meta_ff[g] <= i_d[g];
                    sync_ff[g] <= meta_ff[g];
                end
            end
        end
    endgenerate

    assign o_q = sync_ff;

endmodule : smcf_sync

// file: smcf_shift.sv
/*
 smcf_shift: msb-first byte deserialiser with bit counter.
 assumes: i_en is high for one cycle per captured bit.
*/
`timescale 1ns/100ps
module smcf_shift (
    // clock and reset
    input  wire logic       i_clk_sys,
    input  wire logic       i_srst,
    // control
    input  wire logic       i_clr,
    input  wire logic       i_en,
    input  wire logic       i_bit,
    // result
    output logic      [2:0] o_cnt,
    output logic            o_last,
    output logic      [7:0] o_byte
);
    logic [6:0] data_ff;
    logic [2:0] cnt_ff;
    logic [6:0] nxt_data;
    logic [2:0] nxt_cnt;

    always_comb
    begin
        nxt_data = data_ff;
        nxt_cnt  = cnt_ff;
        if (i_clr)
        begin
            nxt_cnt = 3'h0;
        end
        else if (i_en)
        begin
            nxt_data = {data_ff[5:0], i_bit};
            nxt_cnt  = cnt_ff + 3'h1;
        end
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (i_srst)
        begin
            data_ff <= 7'h00;
            cnt_ff  <= 3'h0;
        end
        else
        begin
            data_ff <= nxt_data;
            cnt_ff  <= nxt_cnt;
        end
    end

    assign o_cnt  = cnt_ff;
    assign o_last = i_en && !i_clr && (cnt_ff == 3'h7);
    assign o_byte = {data_ff, i_bit};

endmodule : smcf_shift

// file: smcf_master_model.sv
/*
 smcf_master_model: behavioural spi master driving the front end pins.
 assumes: called from the bench just after a rising edge of i_clk_sys.
*/
`timescale 1ns/100ps
module smcf_master_model (
    // clock
    input  wire logic i_clk_sys,
    // spi pins
    input  wire logic i_so,
    input  wire logic i_so_oe,
    output logic      o_sck,
    output logic      o_cs_n,
    output logic      o_si
);
    initial
    begin
        o_sck  = 1'b0;
        o_cs_n = 1'b1;
        o_si   = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge i_clk_sys);
    endtask : tick

    // one frame of n bits from d[31] down, so shifted in at each rise
    task automatic frame(input logic m3, input logic [31:0] d, input int n,
                         output logic [7:0] q);
        o_sck <= m3;
        tick(8);
        o_cs_n <= 1'b0;
        tick(8);
        for (int i = 0; i < n; i++)
        begin
            o_sck <= 1'b0;
            o_si  <= d[31-i];
            tick(4);
            o_sck <= 1'b1;
            tick(4);
            q = {q[6:0], i_so_oe ? i_so : 1'b1};
        end
        o_sck <= m3;
        tick(4);
        o_cs_n <= 1'b1;
        o_si   <= ~o_si;
        tick(8);
    endtask : frame
endmodule : smcf_master_model

// file: smcf_top_tb.sv
/*
 smcf_top_tb: self-checking bench of the spi command front end.
 assumes: smcf_master_model drives the spi pins; so idles high when off.
*/
`timescale 1ns/100ps
module smcf_top_tb;
    logic        i_clk_sys = 1'b0;
    logic        i_srst    = 1'b1;
    logic        sck, cs_n, si, so, so_oe, ready, mode3, wen, op_vld, op_bad, a_vld;
    logic [7:0]  status, opcode, q;
    logic [14:0] addr;
    int          num_errors  = 0;
    int          check_count = 0;
    int          n_vld       = 0;
    int          n_bad       = 0;
    int          n_adr       = 0;

    always #4 i_clk_sys = ~i_clk_sys;

    always @(posedge i_clk_sys)
    begin
        n_vld <= n_vld + int'(op_vld === 1'b1);
        n_bad <= n_bad + int'(op_bad === 1'b1);
        n_adr <= n_adr + int'(a_vld === 1'b1);
    end

    smcf_top #(.P_PU_CYCLES(16)) i_dut (
        .i_clk_sys(i_clk_sys), .i_srst(i_srst), .i_sck(sck), .i_cs_n(cs_n),
        .i_si(si), .o_so(so), .o_so_oe(so_oe), .o_ready(ready), .o_mode3(mode3),
        .o_wen(wen), .o_status(status), .o_opcode(opcode), .o_opcode_vld(op_vld),
        .o_opcode_bad(op_bad), .o_addr(addr), .o_addr_vld(a_vld)
    );

    smcf_master_model i_m (
        .i_clk_sys(i_clk_sys), .i_so(so), .i_so_oe(so_oe),
        .o_sck(sck), .o_cs_n(cs_n), .o_si(si)
    );

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic test_done;
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : test_done

    task automatic t_opcodes;
        logic [7:0] tbl [9];
        int         v;
        tbl = '{8'h06, 8'h04, 8'h05, 8'h01, 8'h03, 8'h0b, 8'h02, 8'hb9, 8'h9f};
        foreach (tbl[k])
        begin
            v = n_vld;
            i_m.frame(k[0], {tbl[k], 24'h0}, 8, q);
            chk(n_vld - v, 1);
            chk(opcode, tbl[k]);
            chk(mode3, k[0]);
        end
        chk(n_bad, 0);
        $display("test opcodes done");
    endtask : t_opcodes

    task automatic t_bad;
        int v;
        int b;
        v = n_vld;
        b = n_bad;
        i_m.frame(1'b0, {8'h07, smcf_pkg::READ_STATUS_CMD, 16'h0}, 24, q);
        chk(n_bad - b, 1);
        chk(n_vld - v, 0);
        chk(q, 8'hff);
        $display("test invalid opcode done");
    endtask : t_bad

    task automatic t_write;
        int a;
        i_m.frame(1'b0, {smcf_pkg::SET_WRITE_ENABLE_CMD, 24'h0}, 8, q);
        chk(wen, 1'b1);
        i_m.frame(1'b1, {smcf_pkg::READ_STATUS_CMD, 24'h0}, 16, q);
        chk(q, 8'h02);
        i_m.frame(1'b0, {smcf_pkg::WRITE_STATUS_CMD, 8'hff, 16'h0}, 16, q);
        chk(wen, 1'b0);
        chk(status, 8'h8c);
        i_m.frame(1'b0, {smcf_pkg::WRITE_STATUS_CMD, 8'h00, 16'h0}, 16, q);
        chk(status, 8'h8c);
        i_m.frame(1'b0, {smcf_pkg::SET_WRITE_ENABLE_CMD, 24'h0}, 8, q);
        a = n_adr;
        i_m.frame(1'b1, {smcf_pkg::WRITE_MEMORY_CMD, 16'hc123, 8'h5a}, 32, q);
        chk(addr, 15'h4123);
        chk(n_adr - a, 1);
        chk(wen, 1'b0);
        i_m.frame(1'b0, {smcf_pkg::SET_WRITE_ENABLE_CMD, 24'h0}, 8, q);
        chk(wen, 1'b1);
        i_m.frame(1'b0, {smcf_pkg::CLEAR_WRITE_ENABLE_CMD, 24'h0}, 8, q);
        chk(status[1], 1'b0);
        $display("test write enable done");
    endtask : t_write

    task automatic t_partial;
        int v;
        v = n_vld;
        i_m.frame(1'b0, {smcf_pkg::SET_WRITE_ENABLE_CMD, 24'h0}, 5, q);
        chk(wen, 1'b0);
        chk(n_vld - v, 0);
        $display("test partial opcode done");
    endtask : t_partial

    initial
    begin
        #400000;
        num_errors++;
        test_done();
    end

    initial
    begin
        repeat (16) @(posedge i_clk_sys);
        i_srst <= 1'b0;
        for (int w = 0; w < 100 && ready !== 1'b1; w++)
            @(posedge i_clk_sys);
        chk(ready, 1'b1);
        chk(wen, 1'b0);
        chk(status, smcf_pkg::STATUS_RESET);
        chk(so_oe, 1'b0);
        $display("test reset done");
        t_opcodes();
        t_bad();
        t_write();
        t_partial();
        test_done();
    end
endmodule : smcf_top_tb
